// ===== afc_fifo.sv
// Parameterised result FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module afc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic   ref_clk,  // System clock
  input  wire logic   reset,    // Synchronous, active high
  afc_stream_if.snk   inPort,   // Filling side
  afc_stream_if.src   outPort   // Draining side
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
  } afc_fifo_state_type;

  afc_fifo_state_type fifo_q;
  afc_fifo_state_type fifo_d;
  logic [WIDTH-1:0]   mem [DEPTH];
  logic               full;
  logic               empty;
  logic               push;
  logic               pop;

  assign empty = fifo_q.wrPtr == fifo_q.rdPtr;
  assign full  = (fifo_q.wrPtr[AW] != fifo_q.rdPtr[AW]) &&
                 (fifo_q.wrPtr[AW-1:0] == fifo_q.rdPtr[AW-1:0]);
  assign push  = inPort.valid && !full;
  assign pop   = outPort.ready && !empty;

  assign inPort.ready  = !full;
  assign outPort.valid = !empty;
  assign outPort.data  = mem[fifo_q.rdPtr[AW-1:0]];

  always_comb begin
    fifo_d = fifo_q;
    if (push) begin
      fifo_d.wrPtr = fifo_q.wrPtr + 1'b1;
    end
    if (pop) begin
      fifo_d.rdPtr = fifo_q.rdPtr + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fifo_q <= '0;
    end else begin
      fifo_q <= fifo_d;
    end
    if (push) begin
      mem[fifo_q.wrPtr[AW-1:0]] <= inPort.data;
    end
  end

endmodule : afc_fifo
`default_nettype wire

// ===== afc_frame_ctl.sv
// Conversion frame, serial readout and power mode control of the converter
`timescale 1ns/10ps
`default_nettype none
module afc_frame_ctl #(
  parameter int   RESULT_BITS   = afc_pkg::RESULT_BITS_DEFAULT,
  parameter int   FIFO_DEPTH    = afc_pkg::FIFO_DEPTH_DEFAULT,
  parameter logic START_POWERED = afc_pkg::START_POWERED_DEFAULT
) (
  input  wire logic        ref_clk,          // System clock, 200 MHz
  input  wire logic        reset,            // Synchronous, active high
  input  wire logic        frameSelN,        // Frame select pin, active low
  input  wire logic        serialClk,        // Serial clock pin
  input  wire logic [11:0] sampleData,       // Converted analog_input code
  input  wire logic        sampleValid,      // Code offered
  output logic             sampleReady,      // FIFO can take a code
  output logic             serialResultOut,  // Serial result data
  output logic             serialResultOe,   // High while output driven
  output logic             analogPowerOn,    // Analog circuitry powered
  output logic             fullyPowered,     // Wake-up finished
  output logic             trackActive,      // High in track, low in hold
  output logic             conversionDone,   // Pulse: conversion interval over
  output logic             resultFresh,      // Frame carries a FIFO code
  output logic             quietViolation    // Pulse: frame began too early
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    afc_pkg::afc_mode_type mode;
    logic [2:0]            csPipe;
    logic [2:0]            clkPipe;
    logic [4:0]            fallCnt;
    logic [15:0]           shiftReg;
    logic                  outEn;
    logic                  track;
    logic [7:0]            puTimer;
    logic [3:0]            quietCnt;
    logic                  fresh;
    logic                  donePulse;
    logic                  quietErr;
  } afc_state_type;

  localparam logic [4:0] CONV_END  = afc_pkg::convFalls(RESULT_BITS);
  localparam logic [4:0] TRACK_AT  = afc_pkg::trackFalls(RESULT_BITS);

  afc_state_type st_q;
  afc_state_type st_d;
  logic          csLow;
  logic          csFall;
  logic          csRise;
  logic          sclkFall;
  logic          sclkRise;
  logic          sclkEdge;
  logic          poweredNow;
  logic          takeWord;

  afc_stream_if #(.WIDTH(12)) inIf ();
  afc_stream_if #(.WIDTH(12)) outIf ();

  // ****************************************************************
  // Result buffer
  // ****************************************************************
  assign inIf.valid  = sampleValid;
  assign inIf.data   = sampleData;
  assign sampleReady = inIf.ready;
  assign outIf.ready = takeWord;

  afc_fifo #(
    .WIDTH (12),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk (ref_clk),
    .reset   (reset),
    .inPort  (inIf),
    .outPort (outIf)
  );

  // ****************************************************************
  // Pin edges, taken from the settled stages only
  // ****************************************************************
  assign csLow    = !st_q.csPipe[1];
  assign csFall   = st_q.csPipe[2] && !st_q.csPipe[1];
  assign csRise   = !st_q.csPipe[2] && st_q.csPipe[1];
  assign sclkFall = st_q.clkPipe[2] && !st_q.clkPipe[1];
  assign sclkRise = !st_q.clkPipe[2] && st_q.clkPipe[1];
  assign sclkEdge = st_q.clkPipe[2] ^ st_q.clkPipe[1];
  // wake done by count or time
  assign poweredNow = (st_q.fallCnt == afc_pkg::WORD_FALLS) ||
                      (st_q.puTimer >= afc_pkg::POWERUP_CYC);
  // Codes are consumed by every frame started in ST_ON, power-down and aborted frames too, never by a dummy frame
  assign takeWord = csFall && (st_q.mode == afc_pkg::ST_ON) &&
                    outIf.valid;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d           = st_q;
    st_d.donePulse = 1'b0;
    st_d.quietErr  = 1'b0;
    st_d.csPipe    = {st_q.csPipe[1:0], frameSelN};
    st_d.clkPipe   = {st_q.clkPipe[1:0], serialClk};
    if (!st_q.outEn && st_q.quietCnt != afc_pkg::QUIET_CYC) begin
      st_d.quietCnt = st_q.quietCnt + 4'h1;
    end
    if (csLow && sclkFall && st_q.fallCnt != afc_pkg::WORD_FALLS) begin
      st_d.fallCnt = st_q.fallCnt + 5'h01;
    end
    if (st_q.outEn && sclkFall) begin
      st_d.shiftReg = {st_q.shiftReg[14:0], 1'b0};
      if (st_q.fallCnt == afc_pkg::WORD_FALLS - 5'h01) begin
        st_d.outEn    = 1'b0;
        st_d.quietCnt = 4'h0;
      end
    end

    case (st_q.mode)
      afc_pkg::ST_OFF: begin
        st_d.outEn = 1'b0;
        st_d.track = 1'b0;
        if (csFall) begin
          st_d.mode     = afc_pkg::ST_WAKE;
          st_d.fallCnt  = 5'h00;
          st_d.puTimer  = 8'h00;
          st_d.shiftReg = 16'h0000;
          st_d.outEn    = 1'b1;
          st_d.fresh    = 1'b0;
        end
      end
      afc_pkg::ST_WAKE, afc_pkg::ST_RAMP: begin
        if (st_q.puTimer != afc_pkg::POWERUP_CYC) begin
          st_d.puTimer = st_q.puTimer + 8'h01;
        end
        if (st_q.mode == afc_pkg::ST_WAKE && sclkEdge) begin
          st_d.track = 1'b1;
        end
        if (st_q.mode == afc_pkg::ST_RAMP) begin
          if (poweredNow) begin
            st_d.mode = afc_pkg::ST_ON;
          end
          // A frame during the ramp is treated as another dummy frame
          if (csFall) begin
            st_d.mode     = afc_pkg::ST_WAKE;
            st_d.fallCnt  = 5'h00;
            st_d.shiftReg = 16'h0000;
            st_d.outEn    = 1'b1;
          end
        end else if (csRise) begin
          st_d.outEn = 1'b0;
          if (st_q.outEn) begin
            st_d.quietCnt = 4'h0;
          end
          if (st_q.fallCnt < afc_pkg::NORMAL_MIN_FALLS) begin
            st_d.mode  = afc_pkg::ST_OFF;
            st_d.track = 1'b0;
          end else if (poweredNow) begin
            st_d.mode = afc_pkg::ST_ON;
          end else begin
            st_d.mode = afc_pkg::ST_RAMP;
          end
        end
      end
      afc_pkg::ST_ON: begin
        if (csFall) begin
          st_d.mode     = afc_pkg::ST_CONV;
          st_d.fallCnt  = 5'h00;
          st_d.outEn    = 1'b1;
          st_d.track    = 1'b0;
          st_d.fresh    = outIf.valid;
          st_d.shiftReg = outIf.valid ?
                          afc_pkg::buildWord(RESULT_BITS, outIf.data) :
                          16'h0000;
          st_d.quietErr = st_q.quietCnt != afc_pkg::QUIET_CYC;
        end
      end
      afc_pkg::ST_CONV: begin
        if (sclkFall && st_q.fallCnt == CONV_END - 5'h01) begin
          st_d.donePulse = 1'b1;
        end
        if (sclkRise && st_q.fallCnt >= TRACK_AT) begin
          st_d.track = 1'b1;
        end
        if (csRise) begin
          st_d.outEn = 1'b0;
          if (st_q.outEn) begin
            st_d.quietCnt = 4'h0;
          end
          if (st_q.fallCnt < afc_pkg::PD_MIN_FALLS) begin
            st_d.mode  = afc_pkg::ST_ON;
            st_d.track = 1'b1;
          end else if (st_q.fallCnt < afc_pkg::NORMAL_MIN_FALLS) begin
            st_d.mode  = afc_pkg::ST_OFF;
            st_d.track = 1'b0;
          end else begin
            st_d.mode  = afc_pkg::ST_ON;
            st_d.track = 1'b1;
          end
        end
      end
      default: begin
        st_d.mode  = afc_pkg::ST_OFF;
        st_d.outEn = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q         <= '0;
      st_q.mode    <= START_POWERED ? afc_pkg::ST_ON : afc_pkg::ST_OFF;
      st_q.csPipe  <= afc_pkg::CS_PIPE_RESET;
      st_q.clkPipe <= afc_pkg::CLK_PIPE_RESET;
      st_q.track   <= afc_pkg::TRACK_RESET;
      st_q.quietCnt <= afc_pkg::QUIET_CYC;
    end else begin
      st_q <= st_d;
    end
  end

  assign serialResultOut = st_q.shiftReg[15];
  assign serialResultOe  = st_q.outEn;
  assign analogPowerOn   = st_q.mode != afc_pkg::ST_OFF;
  assign fullyPowered    = (st_q.mode == afc_pkg::ST_ON) ||
                           (st_q.mode == afc_pkg::ST_CONV);
  assign trackActive     = st_q.track;
  assign conversionDone  = st_q.donePulse;
  assign resultFresh     = st_q.fresh;
  assign quietViolation  = st_q.quietErr;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  localparam int PU_BOUND = 201;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_conv_rise;
    csRise && st_q.mode == afc_pkg::ST_CONV;
  endsequence
  sequence s_wake_rise;
    csRise && st_q.mode == afc_pkg::ST_WAKE;
  endsequence

  property p_frame_start;
    csFall && st_q.mode == afc_pkg::ST_ON |=>
      st_q.mode == afc_pkg::ST_CONV && st_q.outEn && !st_q.track &&
      st_q.shiftReg[15:12] == 4'h0 && st_q.fallCnt == 5'h00;
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("frame start did not hold and drive");

  property p_power_down;
    s_conv_rise and (st_q.fallCnt >= afc_pkg::PD_MIN_FALLS &&
                     st_q.fallCnt < afc_pkg::NORMAL_MIN_FALLS) |=>
      !analogPowerOn && !serialResultOe ##1 !analogPowerOn;
  endproperty
  a_power_down: assert property (p_power_down)
    else $error("rise in window did not power down");

  property p_glitch;
    s_conv_rise and (st_q.fallCnt < afc_pkg::PD_MIN_FALLS) |=>
      fullyPowered && !serialResultOe;
  endproperty
  a_glitch: assert property (p_glitch)
    else $error("early rise powered down");

  property p_abort;
    s_conv_rise and (st_q.fallCnt >= afc_pkg::NORMAL_MIN_FALLS) |=>
      st_q.mode == afc_pkg::ST_ON && !serialResultOe && analogPowerOn;
  endproperty
  a_abort: assert property (p_abort)
    else $error("late rise did not abort cleanly");

  property p_wake_reject;
    s_wake_rise and (st_q.fallCnt < afc_pkg::NORMAL_MIN_FALLS) |=>
      st_q.mode == afc_pkg::ST_OFF;
  endproperty
  a_wake_reject: assert property (p_wake_reject)
    else $error("short wake frame did not return to power-down");

  property p_wake_start;
    csFall && st_q.mode == afc_pkg::ST_OFF |=>
      st_q.mode == afc_pkg::ST_WAKE && analogPowerOn;
  endproperty
  a_wake_start: assert property (p_wake_start)
    else $error("select fall did not start wake-up");

  property p_wake_track;
    st_q.mode == afc_pkg::ST_WAKE && sclkEdge && !csRise |=> trackActive;
  endproperty
  a_wake_track: assert property (p_wake_track)
    else $error("track not resumed on first clock edge");

  property p_release;
    st_q.outEn && sclkFall &&
      st_q.fallCnt == afc_pkg::WORD_FALLS - 5'h01 |=> !serialResultOe;
  endproperty
  a_release: assert property (p_release)
    else $error("output not released after sixteenth fall");

  property p_ramp_ends;
    $rose(st_q.mode == afc_pkg::ST_RAMP) |->
      ##[1:PU_BOUND] st_q.mode != afc_pkg::ST_RAMP;
  endproperty
  a_ramp_ends: assert property (p_ramp_ends)
    else $error("power-up did not finish in time");

  property p_shift;
    st_q.outEn && sclkFall && !csRise && st_q.fallCnt < 5'h0F |=>
      serialResultOut == $past(st_q.shiftReg[14]);
  endproperty
  a_shift: assert property (p_shift)
    else $error("serial bit did not advance on clock fall");

endmodule : afc_frame_ctl
`default_nettype wire

// ===== afc_host_model.sv
// Host serial controller model: drives select and clock, reads the word
`timescale 1ns/10ps
`default_nettype none
module afc_host_model (
  input  wire logic  ref_clk,    // System clock, paces the link
  input  wire logic  resultOut,  // Serial result from the device
  output logic       frameSelN,  // Frame select, active low
  output logic       serialClk,  // Serial clock, still outside frames
  output logic [15:0] wordIn,    // Bits read on rising clock edges
  output logic [7:0] edgeCnt     // Clock edges in the current frame
);
  // ****************************************************************
  // Idle levels
  // ****************************************************************
  // Select idles high
  initial begin
    frameSelN = 1'b1;
    serialClk = 1'b0;
    wordIn = 16'h0000;
    edgeCnt = 8'h00;
  end

  // 160 ns link period is 32 system cycles
  task automatic halfPeriod();
    repeat (16) @(negedge ref_clk);
  endtask : halfPeriod

  // ****************************************************************
  // One frame of a given number of clock falls
  // ****************************************************************
  // Fall count chosen by caller
  task automatic frame(input int falls, input int gap);
    int i;
    edgeCnt = 8'h00;
    @(negedge ref_clk);
    frameSelN = 1'b0;
    halfPeriod();
    for (i = 0; i < falls; i++) begin
      serialClk = 1'b1;
      edgeCnt = edgeCnt + 8'h01;
      wordIn = {wordIn[14:0], resultOut};
      halfPeriod();
      serialClk = 1'b0;
      edgeCnt = edgeCnt + 8'h01;
      halfPeriod();
    end
    frameSelN = 1'b1;
    // Caller sets the idle gap; short only to provoke the flag
    repeat (gap) @(negedge ref_clk);
  endtask : frame
endmodule : afc_host_model
`default_nettype wire

// ===== afc_pkg.sv
// Shared constants, types and helpers for the frame and power mode control
package afc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_MHZ         = 200;
  localparam int POWERUP_NS      = 1000;
  localparam int QUIET_NS        = 50;
  // Least times round up to whole clock cycles
  localparam int POWERUP_CYC_INT = (POWERUP_NS * CLK_MHZ + 999) / 1000;
  localparam int QUIET_CYC_INT   = (QUIET_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] POWERUP_CYC = 8'(POWERUP_CYC_INT);
  localparam logic [3:0] QUIET_CYC   = 4'(QUIET_CYC_INT);

  // ****************************************************************
  // Frame counts and word layout
  // ****************************************************************
  localparam int         RESULT_BITS_DEFAULT = 12;
  localparam int         WORD_BITS           = 16;
  localparam int         LEAD_ZEROS          = 4;
  localparam int         FIFO_DEPTH_DEFAULT  = 16;
  localparam logic [4:0] PD_MIN_FALLS        = 5'h02;
  localparam logic [4:0] NORMAL_MIN_FALLS    = 5'h0A;
  localparam logic [4:0] WORD_FALLS          = 5'h10;
  localparam logic [4:0] CONV_FALLS_12       = 5'h10;
  localparam logic [4:0] CONV_FALLS_10       = 5'h0E;
  localparam logic [4:0] CONV_FALLS_8        = 5'h0C;
  localparam logic [4:0] TRACK_FALLS_WIDE    = 5'h0D;
  localparam logic [4:0] TRACK_FALLS_8       = 5'h0B;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic       START_POWERED_DEFAULT = 1'b1;
  localparam logic [2:0] CS_PIPE_RESET         = 3'h7;
  localparam logic [2:0] CLK_PIPE_RESET        = 3'h0;
  localparam logic       TRACK_RESET           = 1'b1;

  // ****************************************************************
  // Mode states
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_OFF  = 5'h01,
    ST_WAKE = 5'h02,
    ST_RAMP = 5'h04,
    ST_ON   = 5'h08,
    ST_CONV = 5'h10
  } afc_mode_type;

  function automatic logic [4:0] convFalls(input int resBits);
    if (resBits == 8) begin
      return CONV_FALLS_8;
    end else if (resBits == 10) begin
      return CONV_FALLS_10;
    end
    return CONV_FALLS_12;
  endfunction : convFalls

  function automatic logic [4:0] trackFalls(input int resBits);
    return (resBits == 8) ? TRACK_FALLS_8 : TRACK_FALLS_WIDE;
  endfunction : trackFalls

  // Leading zeros, result MSB first, then zero padding
  function automatic logic [15:0] buildWord(input int resBits,
                                            input logic [11:0] res);
    if (resBits == 8) begin
      return {4'h0, res[7:0], 4'h0};
    end else if (resBits == 10) begin
      return {4'h0, res[9:0], 2'h0};
    end
    return {4'h0, res};
  endfunction : buildWord

endpackage : afc_pkg

// ===== afc_stream_if.sv
// Valid/ready word stream between the block's own modules
`timescale 1ns/10ps
`default_nettype none
interface afc_stream_if #(parameter int WIDTH = 12);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : afc_stream_if
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the frame and power mode control
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int LIMIT = 40000;
  logic        ref_clk;
  logic        reset;
  logic [11:0] sampleData;
  logic        sampleValid;
  logic        sampleReady;
  logic        serialResultOut;
  logic        serialResultOe;
  logic        analogPowerOn;
  logic        fullyPowered;
  logic        trackActive;
  logic        conversionDone;
  logic        resultFresh;
  logic        quietViolation;
  logic        frameSelN;
  logic        serialClk;
  logic [15:0] wordIn;
  logic [7:0]  edgeCnt;
  logic        oeEarly;
  logic        trkEarly;
  logic        trkFirst;
  int          error_cnt;
  int          comparisons;
  int          cycleCnt;
  int          doneCnt;
  int          quietCnt;

  afc_frame_ctl #(.RESULT_BITS(12), .FIFO_DEPTH(16)) u_afc_frame_ctl (
    .ref_clk(ref_clk), .reset(reset), .frameSelN(frameSelN),
    .serialClk(serialClk), .sampleData(sampleData),
    .sampleValid(sampleValid), .sampleReady(sampleReady),
    .serialResultOut(serialResultOut), .serialResultOe(serialResultOe),
    .analogPowerOn(analogPowerOn), .fullyPowered(fullyPowered),
    .trackActive(trackActive), .conversionDone(conversionDone),
    .resultFresh(resultFresh), .quietViolation(quietViolation));

  // A released line shows the opposite of its last bit, so late reads show
  afc_host_model u_afc_host_model (
    .ref_clk(ref_clk),
    .resultOut(serialResultOe ? serialResultOut : ~serialResultOut),
    .frameSelN(frameSelN),
    .serialClk(serialClk), .wordIn(wordIn), .edgeCnt(edgeCnt));

  // ****************************************************************
  // Clock, monitors and timeout
  // ****************************************************************
  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cycleCnt <= cycleCnt + 1;
    if (conversionDone === 1'b1) doneCnt <= doneCnt + 1;
    if (quietViolation === 1'b1) quietCnt <= quietCnt + 1;
    if (cycleCnt == LIMIT) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  function automatic logic [11:0] codeOf(input int i);
    return 12'(i * 273) ^ 12'hA5C;
  endfunction : codeOf

  // Valid held until the edge that finds ready high
  task automatic push(input logic [11:0] code);
    int n;
    @(negedge ref_clk);
    sampleData = code;
    sampleValid = 1'b1;
    n = 0;
    while (sampleReady !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    sampleValid = 1'b0;
  endtask : push

  // Runs a frame while probing output enable and track state
  task automatic probe(input int falls, input int gap = 40);
    fork
      u_afc_host_model.frame(falls, gap);
      begin
        wait (frameSelN === 1'b0);
        repeat (5) @(negedge ref_clk);
        oeEarly = serialResultOe;
        trkEarly = trackActive;
        wait (edgeCnt >= 8'h01 || frameSelN === 1'b1);
        repeat (6) @(negedge ref_clk);
        trkFirst = trackActive;
      end
    join
  endtask : probe

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    check(16'(serialResultOe), 16'h0000, "oe after reset");
    check(16'(trackActive), 16'h0001, "track after reset");
    check(16'(fullyPowered), 16'h0001, "powered after reset");
    check(16'(sampleReady), 16'h0001, "ready after reset");
    probe(16);
    check(wordIn, 16'h0000, "empty fifo word");
    check(16'(resultFresh), 16'h0000, "empty fifo fresh");
  endtask : t_reset

  task automatic t_fill_drain();
    int i;
    int d0;
    for (i = 0; i < 16; i++) push(codeOf(i));
    @(negedge ref_clk);
    check(16'(sampleReady), 16'h0000, "fifo full refuses");
    for (i = 0; i < 16; i++) begin
      d0 = doneCnt;
      probe(16);
      check(wordIn, {4'h0, codeOf(i)}, "word");
      check(16'(oeEarly), 16'h0001, "oe at select fall");
      check(16'(trkEarly), 16'h0000, "hold at select fall");
      check(16'(resultFresh), 16'h0001, "fresh");
      check(16'(doneCnt - d0), 16'h0001, "one done pulse");
      check(16'(serialResultOe), 16'h0000, "released");
    end
    probe(16);
    check(wordIn, 16'h0000, "drained word");
    check(16'(sampleReady), 16'h0001, "drained ready");
  endtask : t_fill_drain

  task automatic t_glitch_abort();
    int d0;
    int q0;
    probe(0);
    probe(1);
    check(16'(analogPowerOn), 16'h0001, "glitch keeps power");
    check(16'(fullyPowered), 16'h0001, "glitch keeps normal");
    d0 = doneCnt;
    probe(12);
    check(16'(analogPowerOn), 16'h0001, "abort keeps power");
    check(16'(serialResultOe), 16'h0000, "abort releases");
    check(16'(doneCnt - d0), 16'h0000, "abort no done");
    // Aborted frame releases at the rise, so a quick next frame is early
    q0 = quietCnt;
    probe(12, 1);
    probe(16);
    check(16'(quietCnt - q0), 16'h0001, "early frame flagged");
  endtask : t_glitch_abort

  task automatic t_power_cycle(input int pdFalls, input int wakeFalls);
    probe(pdFalls);
    check(16'(analogPowerOn), 16'h0000, "power down");
    check(16'(serialResultOe), 16'h0000, "pd releases");
    check(16'(fullyPowered), 16'h0000, "pd not powered");
    probe(1);
    check(16'(analogPowerOn), 16'h0000, "pd glitch");
    probe(8);
    check(16'(analogPowerOn), 16'h0000, "eight burst");
    probe(wakeFalls);
    check(16'(trkFirst), 16'h0001, "track on first edge");
    check(wordIn, 16'h0000, "dummy word");
    check(16'(fullyPowered), 16'h0001, "woken");
    // Pushed only now: the power-down frame would have consumed it
    push(codeOf(40 + pdFalls));
    probe(16);
    check(wordIn, {4'h0, codeOf(40 + pdFalls)}, "post wake");
    check(16'(resultFresh), 16'h0001, "post wake fresh");
  endtask : t_power_cycle

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    reset = 1'b1;
    sampleData = 12'h000;
    sampleValid = 1'b0;
    error_cnt = 0;
    comparisons = 0;
    cycleCnt = 0;
    doneCnt = 0;
    quietCnt = 0;
    oeEarly = 1'b0;
    trkEarly = 1'b0;
    trkFirst = 1'b0;
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    repeat (3) @(negedge ref_clk);
    t_reset();
    t_fill_drain();
    t_glitch_abort();
    t_power_cycle(2, 16);
    t_power_cycle(9, 10);
    // Only the one deliberately early frame may have been flagged
    check(16'(quietCnt), 16'h0001, "quiet spacing");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
